// [rtl/acsp_consts.svh]
// Constants of the serial configuration port: instruction layout, register
// file, link timing and the controller's APB register map.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef ACSP_CONSTS_SVH
`define ACSP_CONSTS_SVH
`define ACSP_INSTR_BITS 16
`define ACSP_RW_BIT 15
`define ACSP_LEN_MSB 14
`define ACSP_LEN_LSB 13
`define ACSP_ADDR_W 13
`define ACSP_LEN_STREAM 2'b11
`define ACSP_MEM_DEPTH 32
`define ACSP_CFG_IDX 0
`define ACSP_CFG_LSB_BIT 6
`define ACSP_CLK_NS 100
`define ACSP_SCLK_NS 800
`define ACSP_SCLK_HALF (`ACSP_SCLK_NS / `ACSP_CLK_NS / 2)
`define ACSP_STALL_NS 800
`define ACSP_STALL_CYC ((`ACSP_STALL_NS + `ACSP_CLK_NS - 1) / `ACSP_CLK_NS)
`define ACSP_PADDR_W 12
`define ACSP_OFF_CTRL 12'h000
`define ACSP_OFF_WDATA 12'h004
`define ACSP_OFF_RDATA 12'h008
`define ACSP_OFF_STATUS 12'h00c
`define ACSP_CTRL_RW 15
`define ACSP_CTRL_STALL 16
`define ACSP_CTRL_LSB 17
`define ACSP_CTRL_SCNT_LSB 18
`define ACSP_CTRL_START 31
`define ACSP_STAT_BUSY 0
`define ACSP_STAT_DONE 1
`endif

// [rtl/acsp_pkg.sv]
// Types for both ends of the serial configuration port, each type used by one end only.
// Assumes acsp_consts.svh is on the include path.
`include "acsp_consts.svh"
package acsp_pkg;
    typedef enum logic {
        ACSP_D_INSTR = 1'b0,
        ACSP_D_DATA = 1'b1
    } acsp_dev_state_t;

    typedef enum logic [2:0] {
        ACSP_H_IDLE = 3'b000,
        ACSP_H_LEAD = 3'b001,
        ACSP_H_LOW = 3'b010,
        ACSP_H_HIGH = 3'b011,
        ACSP_H_STALL = 3'b100,
        ACSP_H_TAIL = 3'b101
    } acsp_host_state_t;

    typedef struct packed {
        acsp_host_state_t state;
        logic [15:0] cnt;
        logic [5:0] bitidx;
        logic rw;
        logic [1:0] len;
        logic [`ACSP_ADDR_W-1:0] addr;
        logic stall_en;
        logic lsb;
        logic [1:0] scount;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic done;
        logic sclk;
        logic sel_n;
        logic sdo;
        logic oe;
        logic sdi_m;
        logic sdi_s;
        logic [31:0] prdata;
    } acsp_host_regs_t;
endpackage : acsp_pkg

// [rtl/acsp_if.sv]
// Link between controller and device: shift clock, select, shared data line.
// Assumes a weak pull-down on the data line when nobody drives it.
`timescale 1ns/1ns
`default_nettype none
interface acsp_if;
    logic sclk;
    logic port_select_low;
    logic sdio;
    logic sdio_d_o;
    logic sdio_d_oe;
    logic sdio_h_o;
    logic sdio_h_oe;

    // Device wins if both drive; the pull-down keeps the idle line defined
    assign sdio = sdio_d_oe ? sdio_d_o : (sdio_h_oe ? sdio_h_o : 1'b0);

    modport dev (input sclk, input port_select_low, input sdio,
                 output sdio_d_o, output sdio_d_oe);
    modport host (output sclk, output port_select_low, output sdio_h_o,
                  output sdio_h_oe, input sdio);
endinterface : acsp_if
`default_nettype wire

// [rtl/acsp_dev.sv]
// Device end of the serial configuration port: framing, byte register file,
// readback turnaround and pin straps.
// Assumes link pins are asynchronous to pclk and that pclk runs at least
// eight times faster than the shift clock.
// Assumes select sits still for four pclk edges after reset, for the strap.
// Register file index is the low address bits; higher bits alias.
// Limitation: a stream entered in 2-wire mode ends only with reset.
// Behaviour
// RQ1: Select low, then rising edge starts frame
// RQ2: Sixteen-bit instruction, then length-defined data bytes
// RQ3: Select low enables clock and data decoding
// RQ4: Select high between bytes stalls, then resumes; here only before a data byte of a non-streaming frame, else the framer resets
// RQ5: Length code 11 streams until select rises
// RQ6: Select rising mid-byte resets the framer
// RQ7: Select tied high gives strap functions
// RQ8: Select tied low runs 2-wire mode
// RQ9: 2-wire hosts avoid streaming, cannot exit it
// RQ10: Instruction picks write or register readback
// RQ11: Data line turns around for readback
// RQ12: MSB first by default, config selects LSB
// RQ13: Select high ignores clock and data
// RQ14: Data line input on writes, output readback
// RQ15: Instruction is flag, length, 13-bit address
// RQ16: Inputs sampled rising, readback changes falling
`timescale 1ns/1ns
`default_nettype none
`include "acsp_consts.svh"
module acsp_dev #(
    parameter int MEM_DEPTH = `ACSP_MEM_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    acsp_if.dev link,
    input wire logic [$clog2(MEM_DEPTH)-1:0] usr_rd_idx,
    output logic [7:0] usr_rd_data,
    output logic usr_lsb_first,
    output logic usr_frame_active,
    output logic usr_test_pattern,
    output logic usr_low_swing
);
    import acsp_pkg::*;

    localparam int IW = $clog2(MEM_DEPTH);

    typedef struct packed {
        logic sclk_m;
        logic sclk_s;
        logic sclk_p;
        logic sel_m;
        logic sel_s;
        logic sdi_m;
        logic sdi_s;
        logic [1:0] strap_cnt;
        logic strap;
        acsp_dev_state_t state;
        logic ibyte;
        logic [2:0] bitcnt;
        logic [14:0] sh;
        logic rw;
        logic stream;
        logic [1:0] left;
        logic [`ACSP_ADDR_W-1:0] addr;
        logic [7:0] rx;
        logic [7:0] tx;
        logic sdo;
        logic drive;
        logic [7:0] rd;
        logic [MEM_DEPTH-1:0][7:0] mem;
    } acsp_dev_regs_t;

    acsp_dev_regs_t q, d;

    always_comb begin
        logic rise;
        logic fall;
        logic lsb;
        logic [15:0] instr;
        logic [1:0] len;
        logic [7:0] rx_n;
        logic [IW-1:0] idx;
        logic [IW-1:0] nidx;
        rise = q.sclk_s & ~q.sclk_p;
        fall = ~q.sclk_s & q.sclk_p;
        lsb = q.mem[`ACSP_CFG_IDX][`ACSP_CFG_LSB_BIT];
        instr = {q.sh, q.sdi_s};
        len = instr[`ACSP_LEN_MSB:`ACSP_LEN_LSB];
        rx_n = lsb ? {q.sdi_s, q.rx[7:1]} : {q.rx[6:0], q.sdi_s};
        idx = q.addr[IW-1:0];
        nidx = IW'(q.addr + 13'd1);

        d = q;

        // Two flops per pin, plus a third on the clock for edge detection; the first stage feeds no logic
        d.sclk_m = link.sclk;
        d.sclk_s = q.sclk_m;
        d.sclk_p = q.sclk_s;
        d.sel_m = link.port_select_low;
        d.sel_s = q.sel_m;
        d.sdi_m = link.sdio;
        d.sdi_s = q.sdi_m;

        // Registered read port: one cycle from index to data
        d.rd = q.mem[usr_rd_idx];

        // Strap level caught once the synchronisers have settled
        if (q.strap_cnt != 2'd3) begin
            d.strap_cnt = q.strap_cnt + 2'd1;
        end

        if (q.strap_cnt == 2'd2) begin
            d.strap = q.sel_s; // [RQ7]
        end

        if (q.sel_s) begin
            // Select high: clock and data are ignored for register access [RQ13]
            if (q.bitcnt != 3'd0 || q.state != ACSP_D_DATA || q.stream) begin
                // Mid-byte abort, or end of a streaming cycle [RQ6] [RQ5]
                d.state = ACSP_D_INSTR;
                d.bitcnt = 3'd0;
                d.ibyte = 1'b0;
                d.drive = 1'b0;
                d.stream = 1'b0;
            end else if (q.rw) begin
                // Stall on a byte boundary holds state [RQ4]; the falling edge
                // met by the select rise is lost, so the next bit goes out here
                d.sdo = lsb ? q.tx[0] : q.tx[7]; // [RQ11]
            end
        end else if (rise) begin
            // Select low: rising edges clock the frame, also in 2-wire mode [RQ1] [RQ3] [RQ8]
            // Counter wraps at eight, so zero marks a byte boundary
            d.bitcnt = q.bitcnt + 3'd1;

            case (q.state)
                ACSP_D_INSTR: begin
                    // Instruction is always MSB first, whatever the data order
                    d.sh = instr[14:0]; // [RQ16]
                    if (q.bitcnt == 3'd7) begin
                        d.ibyte = ~q.ibyte;
                        if (q.ibyte) begin
                            // Sixteen bits in: decode flag, length, address [RQ2] [RQ15]
                            d.rw = instr[`ACSP_RW_BIT]; // [RQ10]
                            // In 2-wire mode nothing but reset ends a stream
                            d.stream = (len == `ACSP_LEN_STREAM); // [RQ5] [RQ9]
                            d.left = (len == `ACSP_LEN_STREAM) ? 2'd0 : len;
                            d.addr = instr[`ACSP_ADDR_W-1:0];
                            d.tx = q.mem[instr[IW-1:0]];
                            d.state = ACSP_D_DATA;
                        end
                    end
                end

                ACSP_D_DATA: begin
                    if (q.rw) begin
                        d.tx = lsb ? {1'b0, q.tx[7:1]} : {q.tx[6:0], 1'b0}; // [RQ12]
                    end else begin
                        d.rx = rx_n; // [RQ12] [RQ14]
                    end
                    if (q.bitcnt == 3'd7) begin
                        if (!q.rw) begin
                            // Stored on the eighth bit only: an aborted byte is lost
                            d.mem[idx] = rx_n; // [RQ10]
                        end
                        // Ascending addresses; high address bits alias the file
                        d.addr = q.addr + 13'd1;
                        // Next readback byte preloaded for the coming falling edge
                        d.tx = q.mem[nidx];
                        if (!q.stream && q.left == 2'd0) begin
                            d.state = ACSP_D_INSTR; // [RQ2]
                            d.drive = 1'b0;
                        end else if (!q.stream) begin
                            d.left = q.left - 2'd1;
                        end
                    end
                end

                default: begin
                    d.state = ACSP_D_INSTR;
                end
            endcase
        end else if (fall && q.state == ACSP_D_DATA && q.rw) begin
            // Output bit moves on falling edges and at a stall, so the host samples
            // a stable bit late in the next high half
            d.sdo = lsb ? q.tx[0] : q.tx[7]; // [RQ16] [RQ12]
            d.drive = 1'b1; // [RQ11] [RQ14]
        end
    end

    // Whole state in one register; reset leaves the file cleared, MSB first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Drive stops at once while select is high, even during a stall [RQ11]
    assign link.sdio_d_o = q.sdo;
    assign link.sdio_d_oe = q.drive & ~q.sel_s; // [RQ14]
    assign usr_rd_data = q.rd;
    assign usr_lsb_first = q.mem[`ACSP_CFG_IDX][`ACSP_CFG_LSB_BIT];
    assign usr_frame_active = ~q.sel_s &
        (q.state == ACSP_D_DATA | q.ibyte | q.bitcnt != 3'd0);

    // Secondary pin functions only when select sat high at start-up [RQ7]
    assign usr_test_pattern = q.strap & q.sel_s & q.sclk_s;
    assign usr_low_swing = q.strap & q.sel_s & q.sdi_s;
endmodule : acsp_dev
`default_nettype wire

// [rtl/acsp_host.sv]
// Controller end of the serial configuration port with an APB register file.
// Assumes software sets the controller's bit order to match the device's
// configuration register; the shift clock is made here by a divider.
`timescale 1ns/1ns
`default_nettype none
`include "acsp_consts.svh"
module acsp_host #(
    parameter int SCLK_HALF = `ACSP_SCLK_HALF,
    parameter int STALL_CYC = `ACSP_STALL_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ACSP_PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    acsp_if.host link
);
    import acsp_pkg::*;

    acsp_host_regs_t q, d;

    always_comb begin
        logic wr;
        logic busy;
        logic data_ph;
        logic [2:0] nbytes;
        logic [5:0] total;
        logic [5:0] nb;
        logic [5:0] j;
        logic [4:0] pos;
        logic [15:0] instr;
        wr = psel & penable & pwrite;
        busy = (q.state != ACSP_H_IDLE);
        data_ph = (q.bitidx >= 6'd16);
        nbytes = (q.len == `ACSP_LEN_STREAM) ? {1'b0, q.scount} + 3'd1 : {1'b0, q.len} + 3'd1;
        total = 6'd16 + {nbytes, 3'b000};
        nb = q.bitidx + 6'd1;
        j = q.bitidx - 6'd16;
        pos = {j[4:3], q.lsb ? j[2:0] : ~j[2:0]};
        instr = {q.rw, q.len, q.addr};
        d = q;
        d.sdi_m = link.sdio;
        d.sdi_s = q.sdi_m;
        // Read data captured in the setup cycle, so the access needs no wait
        if (psel && !penable) begin
            case (paddr)
                `ACSP_OFF_CTRL: d.prdata = {12'h000, q.scount, q.lsb, q.stall_en,
                                            q.rw, q.len, q.addr};
                `ACSP_OFF_WDATA: d.prdata = q.wdata;
                `ACSP_OFF_RDATA: d.prdata = q.rdata;
                `ACSP_OFF_STATUS: d.prdata = {30'h0, q.done, busy};
                default: d.prdata = 32'h0;
            endcase
        end
        // Settings are frozen while a frame runs; such writes are dropped
        if (wr && !busy && paddr == `ACSP_OFF_CTRL) begin
            d.addr = pwdata[`ACSP_ADDR_W-1:0];
            d.len = pwdata[`ACSP_LEN_MSB:`ACSP_LEN_LSB];
            d.rw = pwdata[`ACSP_CTRL_RW];
            d.stall_en = pwdata[`ACSP_CTRL_STALL];
            d.lsb = pwdata[`ACSP_CTRL_LSB];
            d.scount = pwdata[`ACSP_CTRL_SCNT_LSB+1:`ACSP_CTRL_SCNT_LSB];
            if (pwdata[`ACSP_CTRL_START]) begin
                // Select falls first; the first rise comes a full period later [RQ1]
                d.state = ACSP_H_LEAD;
                d.sel_n = 1'b0;
                d.cnt = 16'd0;
                d.bitidx = 6'd0;
            end
        end
        if (wr && !busy && paddr == `ACSP_OFF_WDATA) begin
            d.wdata = pwdata;
        end
        if (wr && paddr == `ACSP_OFF_STATUS && pwdata[`ACSP_STAT_DONE]) begin
            d.done = 1'b0;
        end
        case (q.state)
            ACSP_H_IDLE: begin
                d.sclk = 1'b0;
                d.oe = 1'b0;
            end
            ACSP_H_LEAD: begin
                d.cnt = q.cnt + 16'd1;
                if (q.cnt == 16'(SCLK_HALF - 1)) begin
                    d.state = ACSP_H_LOW;
                    d.cnt = 16'd0;
                end
            end
            ACSP_H_LOW: begin
                d.cnt = q.cnt + 16'd1;
                if (q.cnt == 16'd0) begin
                    // Line released for the data bytes of a readback [RQ11] [RQ14]
                    d.sdo = data_ph ? q.wdata[pos] : instr[~q.bitidx[3:0]]; // [RQ15] [RQ12]
                    d.oe = ~(q.rw & data_ph);
                end
                if (q.cnt == 16'(SCLK_HALF - 1)) begin
                    d.state = ACSP_H_HIGH;
                    d.sclk = 1'b1; // [RQ16]
                    d.cnt = 16'd0;
                end
            end
            ACSP_H_HIGH: begin
                d.cnt = q.cnt + 16'd1;
                if (q.cnt == 16'(SCLK_HALF - 1)) begin
                    // Sampled late in the high half, well after the device's update
                    if (q.rw && data_ph) begin
                        d.rdata[pos] = q.sdi_s; // [RQ16]
                    end
                    d.sclk = 1'b0;
                    d.cnt = 16'd0;
                    d.bitidx = nb;
                    if (nb == total) begin
                        d.state = ACSP_H_TAIL; // [RQ2] [RQ5]
                    end else if (q.stall_en && nb > 6'd16 && nb[2:0] == 3'd0) begin
                        d.state = ACSP_H_STALL; // [RQ4]
                        d.sel_n = 1'b1;
                        d.oe = 1'b0;
                    end else begin
                        d.state = ACSP_H_LOW;
                    end
                end
            end
            ACSP_H_STALL: begin
                d.cnt = q.cnt + 16'd1;
                if (q.cnt == 16'(STALL_CYC - 1)) begin
                    d.sel_n = 1'b0; // [RQ4]
                    d.state = ACSP_H_LEAD;
                    d.cnt = 16'd0;
                end
            end
            ACSP_H_TAIL: begin
                d.oe = 1'b0;
                d.cnt = q.cnt + 16'd1;
                if (q.cnt == 16'(SCLK_HALF - 1)) begin
                    // Raising select on a byte boundary also ends a stream [RQ5]
                    d.sel_n = 1'b1;
                    d.done = 1'b1;
                    d.state = ACSP_H_IDLE;
                    d.cnt = 16'd0;
                end
            end
            default: begin
                d.state = ACSP_H_IDLE;
                d.sel_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.sel_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~((paddr == `ACSP_OFF_CTRL) |
                     (paddr == `ACSP_OFF_WDATA) | (paddr == `ACSP_OFF_RDATA) |
                     (paddr == `ACSP_OFF_STATUS));
    assign link.sclk = q.sclk;
    assign link.port_select_low = q.sel_n;
    assign link.sdio_h_o = q.sdo;
    assign link.sdio_h_oe = q.oe;
endmodule : acsp_host
`default_nettype wire

// [dv/acsp_link_sva.sv]
// Checker on the link between controller and device.
// Assumes the bench wires the interface signals by name.
`timescale 1ns/1ns
`default_nettype none
module acsp_link_sva #(
    parameter int SCLK_HALF = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sclk,
    input wire logic port_select_low,
    input wire logic sdio_d_o,
    input wire logic sdio_d_oe,
    input wire logic sdio_h_o,
    input wire logic sdio_h_oe
);
    logic [7:0] hi_q;
    logic [2:0] bits_q;
    // Counts the high half so the divider figure is checked exactly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_q <= 8'h00;
            bits_q <= 3'd0;
        end else begin
            hi_q <= sclk ? hi_q + 8'h01 : 8'h00;
            // Rising edges modulo eight; legal frames stop on a multiple
            if (sclk && hi_q == 8'h00) begin
                bits_q <= bits_q + 3'd1;
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_idle_clock_low: assert property (port_select_low |-> !sclk)
        else $error("shift clock moved while deselected");
    a_no_contention: assert property (!(sdio_d_oe && sdio_h_oe))
        else $error("both ends drive the data line");
    a_dev_quiet: assert property (port_select_low [*4] |-> !sdio_d_oe)
        else $error("device drives while deselected");
    a_turn_on_low: assert property ($rose(sdio_d_oe) |-> !sclk && !sdio_h_oe)
        else $error("turnaround at wrong point");
    a_dev_hold_high: assert property (sclk && $past(sclk) && $past(sdio_d_oe)
        |-> $stable(sdio_d_o)) else $error("readback bit moved in high half");
    a_host_hold_high: assert property (sclk && $past(sclk) && sdio_h_oe
        |-> $stable(sdio_h_o)) else $error("write bit moved in high half");
    a_high_span: assert property ($fell(sclk) |-> hi_q == 8'(SCLK_HALF))
        else $error("high half length wrong");
    a_lead_half: assert property ($fell(port_select_low) |-> !sclk [*8] ##1 sclk)
        else $error("frame start timing wrong");
    a_byte_bound: assert property ($rose(port_select_low) |-> !sclk && bits_q == 3'd0)
        else $error("select rose inside a byte");
    c_readback: cover property ($rose(sdio_d_oe));
    c_stall: cover property ($rose(port_select_low) ##[1:20] $fell(port_select_low));
    c_frame: cover property ($fell(port_select_low));
endmodule : acsp_link_sva
`default_nettype wire

// [dv/acsp_bench.sv]
// Bench: controller and device on one link, second device on a link
// driven directly by the bench for aborts, straps and 2-wire mode.
// Assumes default divider values and a 10 MHz pclk.
`timescale 1ns/1ns
`default_nettype none
module acsp_bench;
    import acsp_pkg::*;
    localparam int HALF = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic rst2_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [4:0] rd_idx = 5'h00;
    logic [7:0] d1_data;
    logic [7:0] d2_data;
    logic d1_lsb;
    logic d2_tp;
    logic d2_ls;
    logic d2_fa;
    logic [63:0] cap = 64'h0;
    logic [31:0] rv;
    logic err;
    int n_mismatch = 0;
    int checks_done = 0;
    int j;
    acsp_if if1();
    acsp_if if2();
    always #50 pclk = ~pclk;
    always @(posedge if1.sclk) cap <= {cap[62:0], if1.sdio};
    acsp_host #(.SCLK_HALF(HALF)) acsp_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(if1.host));
    acsp_dev acsp_dev_inst (.pclk(pclk), .presetn(presetn), .link(if1.dev), .usr_rd_idx(rd_idx),
        .usr_rd_data(d1_data), .usr_lsb_first(d1_lsb), .usr_frame_active(),
        .usr_test_pattern(), .usr_low_swing());
    acsp_dev acsp_dev2_inst (.pclk(pclk), .presetn(rst2_n), .link(if2.dev), .usr_rd_idx(rd_idx),
        .usr_rd_data(d2_data), .usr_lsb_first(), .usr_frame_active(d2_fa),
        .usr_test_pattern(d2_tp), .usr_low_swing(d2_ls));
    acsp_link_sva #(.SCLK_HALF(HALF)) acsp_link_sva_inst (.pclk(pclk), .presetn(presetn),
        .sclk(if1.sclk), .port_select_low(if1.port_select_low), .sdio_d_o(if1.sdio_d_o),
        .sdio_d_oe(if1.sdio_d_oe), .sdio_h_o(if1.sdio_h_o), .sdio_h_oe(if1.sdio_h_oe));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // Whole controller transfer: load data, start, poll done, clear it
    task automatic op(input logic [31:0] ctl, input logic [31:0] wd);
        int k;
        cap = 64'h0;
        apb(1'b1, 12'h004, wd);
        apb(1'b1, 12'h000, ctl | 32'h8000_0000);
        rv = 32'h0;
        for (k = 0; k < 2000 && rv[1] !== 1'b1; k++) apb(1'b0, 12'h00c, 32'h0);
        chk(32'(rv[1:0]), 32'h2);
        apb(1'b1, 12'h00c, 32'h2);
    endtask : op
    task automatic peek(input logic [4:0] i);
        rd_idx <= i;
        repeat (3) @(posedge pclk);
    endtask : peek
    // Bit-bangs the second link; data changes with the falling clock
    task automatic bb(input logic [23:0] v, input int n);
        int i;
        for (i = n - 1; i >= 0; i--) begin
            if2.sdio_h_o <= v[i];
            repeat (4) @(posedge pclk);
            if2.sclk <= 1'b1;
            repeat (4) @(posedge pclk);
            if2.sclk <= 1'b0;
        end
        repeat (4) @(posedge pclk);
    endtask : bb
    initial begin
        repeat (40000) @(posedge pclk);
        n_mismatch++;
        final_report();
    end
    initial begin
        if2.sclk = 1'b0;
        if2.port_select_low = 1'b1;
        if2.sdio_h_o = 1'b0;
        if2.sdio_h_oe = 1'b1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rst2_n <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, 12'h00c, 32'h0);
        chk(rv, 32'h0);
        chk(32'(d1_lsb), 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk(32'(err), 32'h1);
        chk(rv, 32'h0);
        op(32'h0000_0005, 32'ha5);
        chk(cap[31:0], 32'h0000_05a5);
        peek(5'd5);
        chk(32'(d1_data), 32'ha5);
        op(32'h0001_4008, 32'h0033_2211);
        chk(cap[31:0], 32'h0811_2233);
        for (j = 0; j < 3; j++) begin
            peek(5'(8 + j));
            chk(32'(d1_data), 32'(8'h11 * (j + 1)));
        end
        op(32'h0000_a008, 32'h0);
        chk(cap[31:0], 32'ha008_1122);
        apb(1'b0, 12'h008, 32'h0);
        chk(rv, 32'h0000_2211);
        op(32'h000c_600c, 32'h7766_5544);
        for (j = 0; j < 4; j++) begin
            peek(5'(12 + j));
            chk(32'(d1_data), 32'(8'h44 + 8'h11 * j));
        end
        op(32'h0001_a00c, 32'h0);
        chk(cap[31:0], 32'ha00c_4455);
        apb(1'b0, 12'h008, 32'h0);
        chk(rv, 32'h0000_5544);
        op(32'h0000_0000, 32'h40);
        op(32'h0002_0001, 32'h03);
        chk(32'(cap[7:0]), 32'hc0);
        peek(5'd1);
        chk(32'(d1_data), 32'h03);
        chk(32'(d1_lsb), 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        chk(rv, 32'h0002_0001);
        bb(24'h0006ff, 24);
        if2.sclk <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(32'({d2_tp, d2_ls}), 32'h3);
        if2.sclk <= 1'b0;
        if2.sdio_h_o <= 1'b0;
        repeat (6) @(posedge pclk);
        chk(32'({d2_tp, d2_ls}), 32'h0);
        peek(5'd6);
        chk(32'(d2_data), 32'h0);
        if2.port_select_low <= 1'b0;
        bb(24'h000003, 16);
        chk(32'(d2_fa), 32'h1);
        bb(24'h00000f, 4);
        if2.port_select_low <= 1'b1;
        repeat (8) @(posedge pclk);
        if2.port_select_low <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(32'(d2_fa), 32'h0);
        bb(24'h00035a, 24);
        if2.port_select_low <= 1'b1;
        repeat (8) @(posedge pclk);
        peek(5'd3);
        chk(32'(d2_data), 32'h5a);
        // 2-wire: select held low through reset, framing from reset alone
        if2.port_select_low <= 1'b0;
        rst2_n <= 1'b0;
        repeat (4) @(posedge pclk);
        rst2_n <= 1'b1;
        repeat (6) @(posedge pclk);
        bb(24'h00043c, 24);
        bb(24'h000781, 24);
        peek(5'd4);
        chk(32'(d2_data), 32'h3c);
        peek(5'd7);
        chk(32'(d2_data), 32'h81);
        final_report();
    end
endmodule : acsp_bench
`default_nettype wire
